// ===== logic/mxb_top.sv
/*
 Memory decoder and external memory bus of an 8-bit microcomputer: mapping
 register, vector and call table addresses, internal PROM/RAM access and the
 multiplexed external bus with latch, read and write strobes.
 Assumes one 125 MHz clock, a synchronous low reset, pins sampled here, and an
 internal PROM macro answering one clock after its address.
*/
`timescale 1ns/1ns
`include "mxb_defines.svh"

module mxb_top
    import mxb_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_stop_b,
    input  wire logic        i_mode_select_a,
    input  wire logic        i_mode_select_b,
    input  wire logic        i_mm_we,
    input  wire logic [7:0]  i_mm_wdata,
    output logic      [7:0]  o_memory_map_register,
    input  wire logic        i_acc_req,
    input  wire logic        i_acc_we,
    input  wire logic [15:0] i_acc_addr,
    input  wire logic [7:0]  i_acc_wdata,
    output logic      [7:0]  o_acc_rdata,
    output logic             o_acc_done,
    output logic             o_acc_busy,
    output logic      [14:0] o_prom_addr,
    input  wire logic [7:0]  i_prom_rdata,
    input  wire logic [2:0]  i_vec_src,
    input  wire logic [4:0]  i_call_idx,
    output logic      [15:0] o_vec_addr,
    output logic      [15:0] o_call_addr,
    input  wire logic [7:0]  i_low_multiplexed_port,
    output logic      [7:0]  o_low_multiplexed_port,
    output logic             o_low_multiplexed_port_oe,
    output logic      [7:0]  o_high_address_port,
    output logic      [7:0]  o_high_address_port_oe,
    output logic             o_wr_strobe_b,
    output logic             o_wr_strobe_oe,
    output logic             o_rd_strobe_b,
    output logic             o_rd_strobe_oe,
    output logic             o_ale,
    output logic             o_ale_oe,
    output logic             o_normal_mode,
    output logic             o_prog_mode,
    output logic             o_stopped
);

    localparam logic [3:0] ADDR_LOAD   = 4'(`MXB_ADDR_CYC - 1);
    localparam logic [3:0] STROBE_LOAD = 4'(`MXB_STROBE_CYC - 1);

    mxb_state_type  state, next_state;
    mxb_region_type region_l;
    logic [3:0]     cnt;
    logic [15:0]    addr_l, cur_addr;
    logic [7:0]     wdata_l, cur_wdata;
    logic           we_l, cur_we;
    logic [2:0]     prom_area, ext_sel;
    logic           ram_access_enable;
    logic           take, ext_bus_on;
    logic           stop_s1, stop_s2;
    logic           mode_a_s1, mode_a_s2;
    logic           mode_b_s1, mode_b_s2;
    logic [7:0]     port_s1, port_s2;
    logic [7:0]     prom_q, ram_rdata;
    logic           ram_we, stopped;

    mxb_dec_if dif ();

    // ========================================
    // Pin synchronisers
    always_ff @(posedge i_sys_clk) begin
        stop_s1   <= i_stop_b;
        stop_s2   <= stop_s1;
        mode_a_s1 <= i_mode_select_a;
        mode_a_s2 <= mode_a_s1;
        mode_b_s1 <= i_mode_select_b;
        mode_b_s2 <= mode_b_s1;
        port_s1   <= i_low_multiplexed_port;
        port_s2   <= port_s1;
    end
    assign stopped = !stop_s2;
    // ========================================
    // Mode pin status
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_normal_mode <= 1'b0;
        end else begin
            o_normal_mode <= !mode_a_s2 && mode_b_s2;
        end
        o_prog_mode <= mode_a_s2 && !mode_b_s2 && !i_rst_b;
        o_stopped   <= stopped;
    end

    // ========================================
    // Memory mapping register
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b || stopped) begin
            prom_area <= `MXB_AREA_RST;
            ext_sel   <= `MXB_EXT_SEL_RST;
        end else if (i_mm_we) begin
            prom_area <= i_mm_wdata[`MXB_MM_AREA_LSB +: 3];
            ext_sel   <= i_mm_wdata[`MXB_MM_EXT_LSB +: 3];
        end
    end

    // Deliberately outside reset; undefined until software writes it
    always_ff @(posedge i_sys_clk) begin
        if (i_rst_b && !stopped && i_mm_we) begin
            ram_access_enable <= i_mm_wdata[`MXB_MM_RAE_BIT];
        end
    end
    assign o_memory_map_register = {prom_area, 1'b0, ram_access_enable, ext_sel};
    // ========================================
    // Address decode
    assign cur_addr   = (state == MXB_IDLE) ? i_acc_addr : addr_l;
    assign cur_wdata  = (state == MXB_IDLE) ? i_acc_wdata : wdata_l;
    assign cur_we     = (state == MXB_IDLE) ? i_acc_we : we_l;
    assign dif.addr      = cur_addr;
    assign dif.prom_area = prom_area;
    assign dif.ext_sel   = ext_sel;
    assign dif.ram_access_enable       = ram_access_enable;
    // Port mode: no bus exists, external accesses complete without a cycle
    assign ext_bus_on = (ext_sel >= `MXB_EXT_256);
    assign take       = i_acc_req && (state == MXB_IDLE) && !stopped;

    mxb_decoder u_decoder (
        .dif (dif)
    );

    // ========================================
    // Vector and call table addresses
    always_ff @(posedge i_sys_clk) begin
        case (i_vec_src)
            MXB_VS_RESET:  o_vec_addr <= `MXB_VEC_RESET_ADDR;
            MXB_VS_NMI:    o_vec_addr <= `MXB_VEC_NMI_ADDR;
            MXB_VS_TIMER:  o_vec_addr <= `MXB_VEC_TIMER_ADDR;
            MXB_VS_EXTIRQ: o_vec_addr <= `MXB_VEC_EXTIRQ_ADDR;
            MXB_VS_EVENT:  o_vec_addr <= `MXB_VEC_EVENT_ADDR;
            MXB_VS_EDGE:   o_vec_addr <= `MXB_VEC_EDGE_ADDR;
            MXB_VS_SERIAL: o_vec_addr <= `MXB_VEC_SERIAL_ADDR;
            MXB_VS_TRAP:   o_vec_addr <= `MXB_VEC_TRAP_ADDR;
            default:       o_vec_addr <= `MXB_VEC_RESET_ADDR;
        endcase
        o_call_addr <= `MXB_CALL_BASE + {10'h000, i_call_idx, 1'b0};
    end

    // ========================================
    // Bus sequencer
    always_comb begin
        next_state = state;
        case (state)
            MXB_IDLE: begin
                if (take) begin
                    if (dif.region != MXB_REG_EXT) begin
                        next_state = MXB_INT;
                    end else if (ext_bus_on) begin
                        next_state = MXB_ADDR;
                    end else begin
                        next_state = MXB_RECOVER;
                    end
                end
            end
            MXB_INT:      next_state = MXB_INT_DONE;
            MXB_INT_DONE: next_state = MXB_IDLE;
            MXB_ADDR: begin
                if (cnt == 4'h0) begin
                    next_state = MXB_DATA;
                end
            end
            MXB_DATA: begin
                if (cnt == 4'h0) begin
                    next_state = MXB_RECOVER;
                end
            end
            MXB_RECOVER:  next_state = MXB_IDLE;
            default:      next_state = MXB_IDLE;
        endcase
        // Stop aborts a cycle; the strobes float anyway
        if (stopped) begin
            next_state = MXB_IDLE;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            state <= MXB_IDLE;
            cnt   <= 4'h0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                cnt <= (next_state == MXB_ADDR) ? ADDR_LOAD : STROBE_LOAD;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            addr_l   <= 16'h0000;
            wdata_l  <= 8'h00;
            we_l     <= 1'b0;
            region_l <= MXB_REG_PROM;
        end else if (take) begin
            addr_l   <= i_acc_addr;
            wdata_l  <= i_acc_wdata;
            we_l     <= i_acc_we;
            region_l <= dif.region;
        end
    end

    // ========================================
    // Internal PROM and RAM access
    assign ram_we = (state == MXB_INT) && we_l && (region_l == MXB_REG_RAM);

    mxb_int_ram u_ram (
        .i_sys_clk (i_sys_clk),
        .i_we      (ram_we),
        .i_addr    (addr_l[7:0]),
        .i_wdata   (wdata_l),
        .o_rdata   (ram_rdata)
    );

    always_ff @(posedge i_sys_clk) begin
        if (take) begin
            o_prom_addr <= i_acc_addr[14:0];
        end
        if (state == MXB_INT) begin
            prom_q <= i_prom_rdata;
        end
    end

    // ========================================
    // Access answer
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_acc_rdata <= 8'h00;
            o_acc_done  <= 1'b0;
            o_acc_busy  <= 1'b0;
        end else begin
            o_acc_busy <= (next_state != MXB_IDLE);
            o_acc_done <= !stopped && (state == MXB_RECOVER || state == MXB_INT_DONE);
            if (take && dif.region == MXB_REG_EXT && !ext_bus_on) begin
                o_acc_rdata <= `MXB_NO_BUS_DATA;
            end else if (state == MXB_INT_DONE) begin
                o_acc_rdata <= (region_l == MXB_REG_RAM) ? ram_rdata : prom_q;
            end else if (state == MXB_DATA && cnt == 4'h0 && !we_l) begin
                o_acc_rdata <= port_s2;
            end
        end
    end

    // ========================================
    // External bus pins
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_ale                     <= 1'b0;
            o_wr_strobe_b             <= 1'b1;
            o_rd_strobe_b             <= 1'b1;
            o_low_multiplexed_port    <= 8'h00;
            o_low_multiplexed_port_oe <= 1'b0;
            o_high_address_port       <= 8'h00;
            o_high_address_port_oe    <= 8'h00;
        end else begin
            o_ale <= (next_state == MXB_ADDR);
            o_wr_strobe_b <= !(next_state == MXB_DATA && cur_we);
            o_rd_strobe_b <= !(next_state == MXB_DATA && !cur_we);
            // Address then data on one port
            o_low_multiplexed_port    <= (next_state == MXB_ADDR) ? cur_addr[7:0] : cur_wdata;
            o_low_multiplexed_port_oe <= (next_state == MXB_ADDR) || (next_state == MXB_DATA && cur_we);
            // High byte on its own port
            o_high_address_port <= cur_addr[15:8];
            o_high_address_port_oe <= (next_state == MXB_ADDR || next_state == MXB_DATA)
                                      ? dif.hi_addr_mask : 8'h00;
        end
    end

    // Strobe drivers released while reset is low or stop is active
    always_ff @(posedge i_sys_clk) begin
        o_wr_strobe_oe <= i_rst_b && !stopped;
        o_rd_strobe_oe <= i_rst_b && !stopped;
        o_ale_oe       <= i_rst_b && !stopped;
    end

    // ========================================
    // Checks
    a_wr_strobe_cause: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !o_wr_strobe_b |-> (state == MXB_DATA && we_l))
        else $error("write strobe low outside a write data phase");
    a_rd_strobe_width: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b || stopped)
        $fell(o_rd_strobe_b) |-> (!o_rd_strobe_b && !we_l)[*8])
        else $error("read strobe too short or on a write");
    a_float_in_reset: assert property (@(posedge i_sys_clk)
        (!i_rst_b || stopped) |=> (!o_wr_strobe_oe && !o_rd_strobe_oe && !o_ale_oe))
        else $error("strobe driven during reset or stop");
    a_ale_addr_phase: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state == MXB_ADDR) |-> (o_ale && o_low_multiplexed_port_oe && o_low_multiplexed_port == addr_l[7:0]))
        else $error("address phase without latch pulse and low address");
    a_mm_clear: assert property (@(posedge i_sys_clk)
        (!i_rst_b || stopped) |=> (prom_area == `MXB_AREA_RST && ext_sel == `MXB_EXT_SEL_RST))
        else $error("mapping fields not cleared by reset or stop");
    // Case equality: the enable is legitimately unknown until first written
    a_rae_kept: assert property (@(posedge i_sys_clk)
        (!i_rst_b) |=> (ram_access_enable === $past(ram_access_enable)))
        else $error("RAM enable changed by reset");
    a_call_entry: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        1'b1 |=> (o_call_addr == `MXB_CALL_BASE + {10'h000, $past(i_call_idx), 1'b0} && o_call_addr < `MXB_CALL_LAST))
        else $error("call table entry address wrong");
    a_user_area: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        1'b1 |=> (o_call_addr + 16'h0001 < `MXB_USER_BASE))
        else $error("call table entry reaches user area");
    a_small_layout: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (take && prom_area == `MXB_AREA_4K && ram_access_enable && i_acc_addr > `MXB_PROM_LAST_4K
         && i_acc_addr <= `MXB_EXT_LAST_SMALL) |=> (region_l == MXB_REG_EXT))
        else $error("small layout external span decoded wrongly");
    a_hi_addr_mask: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state == MXB_DATA) |-> (o_high_address_port_oe == dif.hi_addr_mask
                                 && o_high_address_port == addr_l[15:8]))
        else $error("high address pins not matching capacity");

endmodule

// ===== logic/mxb_defines.svh
/*
 Constants of the memory decoder and external bus block: vector and call table
 addresses, decode limits, memory mapping register fields, reset values and bus
 timing. Assumes a 125 MHz system clock; included by bare name.
*/
`ifndef MXB_DEFINES_SVH
`define MXB_DEFINES_SVH

// ========================================
// Vector area and call table
`define MXB_VEC_RESET_ADDR   16'h0000
`define MXB_VEC_NMI_ADDR     16'h0004
`define MXB_VEC_TIMER_ADDR   16'h0008
`define MXB_VEC_EXTIRQ_ADDR  16'h0010
`define MXB_VEC_EVENT_ADDR   16'h0018
`define MXB_VEC_EDGE_ADDR    16'h0020
`define MXB_VEC_SERIAL_ADDR  16'h0028
`define MXB_VEC_TRAP_ADDR    16'h0060
`define MXB_CALL_BASE        16'h0080
`define MXB_CALL_LAST        16'h00BF
`define MXB_USER_BASE        16'h00C0

// ========================================
// Decode limits
`define MXB_PROM_LAST_4K     16'h0FFF
`define MXB_PROM_LAST_8K     16'h1FFF
`define MXB_PROM_LAST_16K    16'h3FFF
`define MXB_PROM_LAST_32K    16'h7FFF
`define MXB_EXT_LAST_SMALL   16'hFEFF
`define MXB_RAM_BASE         16'hFF00

// ========================================
// Memory mapping register fields and codes
`define MXB_MM_EXT_LSB       0
`define MXB_MM_RAE_BIT       3
`define MXB_MM_AREA_LSB      5
`define MXB_AREA_RST         3'h0
`define MXB_EXT_SEL_RST      3'h0
`define MXB_AREA_4K          3'h4
`define MXB_AREA_8K          3'h5
`define MXB_AREA_16K         3'h6
`define MXB_EXT_256          3'h4
`define MXB_EXT_4K           3'h5
`define MXB_EXT_16K          3'h6
`define MXB_EXT_FULL         3'h7
`define MXB_HI_MASK_NONE     8'h00
`define MXB_HI_MASK_4K       8'h0F
`define MXB_HI_MASK_16K      8'h3F
`define MXB_HI_MASK_FULL     8'hFF
`define MXB_NO_BUS_DATA      8'hFF

// ========================================
// Bus timing
`define MXB_CLK_NS           8
`define MXB_ADDR_NS          16
`define MXB_STROBE_NS        80
`define MXB_ADDR_CYC         ((`MXB_ADDR_NS + `MXB_CLK_NS - 1) / `MXB_CLK_NS)
`define MXB_STROBE_CYC       ((`MXB_STROBE_NS + `MXB_CLK_NS - 1) / `MXB_CLK_NS)

`endif

// ===== logic/mxb_pkg.sv
/*
 Types of the memory decoder and external bus block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package mxb_pkg;

    typedef enum logic [2:0] {
        MXB_IDLE     = 3'h0,
        MXB_ADDR     = 3'h1,
        MXB_DATA     = 3'h2,
        MXB_RECOVER  = 3'h3,
        MXB_INT      = 3'h4,
        MXB_INT_DONE = 3'h5
    } mxb_state_type;

    typedef enum logic [1:0] {
        MXB_REG_PROM = 2'h0,
        MXB_REG_RAM  = 2'h1,
        MXB_REG_EXT  = 2'h2
    } mxb_region_type;

    typedef enum logic [2:0] {
        MXB_VS_RESET  = 3'h0,
        MXB_VS_NMI    = 3'h1,
        MXB_VS_TIMER  = 3'h2,
        MXB_VS_EXTIRQ = 3'h3,
        MXB_VS_EVENT  = 3'h4,
        MXB_VS_EDGE   = 3'h5,
        MXB_VS_SERIAL = 3'h6,
        MXB_VS_TRAP   = 3'h7
    } mxb_vec_src_type;

endpackage

// ===== logic/mxb_dec_if.sv
/*
 Carrier between the bus controller and the address decoder.
 Assumes the controller drives the address and mapping fields.
*/
`timescale 1ns/1ns
interface mxb_dec_if;
    import mxb_pkg::*;
    logic [15:0]    addr;
    logic [2:0]     prom_area;
    logic [2:0]     ext_sel;
    logic           ram_access_enable;
    mxb_region_type region;
    logic [7:0]     hi_addr_mask;

    modport dec (input addr, prom_area, ext_sel, ram_access_enable, output region, hi_addr_mask);
    modport ctl (output addr, prom_area, ext_sel, ram_access_enable, input region, hi_addr_mask);
endinterface

// ===== logic/mxb_decoder.sv
/*
 Combinational address decoder: internal PROM window, internal RAM window,
 external space, and which high address bits are bus outputs.
 Assumes the mapping fields come from registers on the system clock.
*/
`timescale 1ns/1ns
`include "mxb_defines.svh"
module mxb_decoder
    import mxb_pkg::*;
(
    mxb_dec_if.dec dif
);

    function automatic logic [15:0] prom_last(input logic [2:0] area);
        case (area)
            `MXB_AREA_4K:  prom_last = `MXB_PROM_LAST_4K;
            `MXB_AREA_8K:  prom_last = `MXB_PROM_LAST_8K;
            `MXB_AREA_16K: prom_last = `MXB_PROM_LAST_16K;
            default:       prom_last = `MXB_PROM_LAST_32K;
        endcase
    endfunction

    // ========================================
    // Region decode
    always_comb begin
        if (dif.addr <= prom_last(dif.prom_area)) begin
            dif.region = MXB_REG_PROM;
        end else if (dif.addr >= `MXB_RAM_BASE && dif.ram_access_enable) begin
            dif.region = MXB_REG_RAM;
        end else begin
            dif.region = MXB_REG_EXT;
        end
    end

    // ========================================
    // High address pins in use
    always_comb begin
        case (dif.ext_sel)
            `MXB_EXT_4K:   dif.hi_addr_mask = `MXB_HI_MASK_4K;
            `MXB_EXT_16K:  dif.hi_addr_mask = `MXB_HI_MASK_16K;
            `MXB_EXT_FULL: dif.hi_addr_mask = `MXB_HI_MASK_FULL;
            default:       dif.hi_addr_mask = `MXB_HI_MASK_NONE;
        endcase
    end

endmodule

// ===== logic/mxb_int_ram.sv
/*
 Internal RAM of 256 bytes with registered read.
 Assumes write enable and address come from the system clock domain.
*/
`timescale 1ns/1ns
module mxb_int_ram (
    input  wire logic       i_sys_clk,
    input  wire logic       i_we,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata
);

    logic [7:0] mem [0:255];

    // ========================================
    // No reset: contents survive stop and reset
    // Contents retained
    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end

endmodule

// ===== tb/mxb_ext_mem.sv
/*
 Behavioural external memory on the multiplexed bus.
 Assumes the bench resolves the shared byte pad from the controller's output enable alone.
*/
`timescale 1ns/1ns
module mxb_ext_mem (
    input  wire logic       i_sys_clk,
    input  wire logic       i_ale,
    input  wire logic       i_rd_b,
    input  wire logic       i_wr_b,
    input  wire logic [7:0] i_hi,
    input  wire logic [7:0] i_port,
    output logic      [7:0] o_port
);
    logic [7:0]  mem [0:65535];
    logic [15:0] lat;
    logic [7:0]  junk = 8'h5A;
    // ========================================
    // Latch and store
    always @(posedge i_sys_clk) begin
        junk <= ~junk;
        if (i_ale) lat <= {i_hi, i_port};
        if (!i_wr_b) mem[lat] <= i_port;
    end
    // Released bus toggles so stale data never reads as valid
    // drive on read
    assign o_port = !i_rd_b ? mem[lat] : junk;
endmodule

// ===== tb/memory_map_and_external_bus_tb.sv
/*
 Self-checking bench of the memory decoder and external bus.
 Assumes mxb_top and the external memory model are compiled first.
*/
`timescale 1ns/1ns
module memory_map_and_external_bus_tb;
    import mxb_pkg::*;
    typedef struct { logic [15:0] vec; logic [4:0] idx; } mxb_row_type;
    logic        clk = 0, rst_b = 0, stop_b = 1, ma = 0, mb = 1, mm_we = 0, req = 0, we = 0;
    logic [7:0]  mm_d = 0, wd = 0, rd, mm_q, pd_o, mem_o, pad, hi, hi_oe, hi_seen;
    logic [14:0] pa;
    logic [15:0] ad = 0, va, ca;
    logic [2:0]  vs = 0;
    logic [4:0]  ci = 0;
    logic        pd_oe, wr_b, rd_b, ale, wr_oe, rd_oe, ale_oe, done, nm, pm, busy, st;
    int          n_errors = 0, comparisons = 0, rd_n = 0, wr_n = 0;
    mxb_row_type rows [8] = '{'{16'h0000, 5'h00}, '{16'h0004, 5'h01}, '{16'h0008, 5'h02},
        '{16'h0010, 5'h05}, '{16'h0018, 5'h0A}, '{16'h0020, 5'h14}, '{16'h0028, 5'h1E}, '{16'h0060, 5'h1F}};
    assign pad = pd_oe ? pd_o : mem_o;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        rd_n += !rd_b;
        wr_n += !wr_b;
        if (ale) hi_seen = hi_oe;
    end
    mxb_top i_mxb_top (.i_sys_clk(clk), .i_rst_b(rst_b), .i_stop_b(stop_b), .i_mode_select_a(ma),
        .i_mode_select_b(mb), .i_mm_we(mm_we), .i_mm_wdata(mm_d), .o_memory_map_register(mm_q),
        .i_acc_req(req), .i_acc_we(we), .i_acc_addr(ad), .i_acc_wdata(wd), .o_acc_rdata(rd),
        .o_acc_done(done), .o_acc_busy(busy), .o_prom_addr(pa), .i_prom_rdata(8'hC3), .i_vec_src(vs),
        .i_call_idx(ci), .o_vec_addr(va), .o_call_addr(ca), .i_low_multiplexed_port(pad),
        .o_low_multiplexed_port(pd_o), .o_low_multiplexed_port_oe(pd_oe), .o_high_address_port(hi),
        .o_high_address_port_oe(hi_oe), .o_wr_strobe_b(wr_b), .o_wr_strobe_oe(wr_oe), .o_rd_strobe_b(rd_b),
        .o_rd_strobe_oe(rd_oe), .o_ale(ale), .o_ale_oe(ale_oe), .o_normal_mode(nm), .o_prog_mode(pm),
        .o_stopped(st));
    mxb_ext_mem i_mxb_ext_mem (.i_sys_clk(clk), .i_ale(ale), .i_rd_b(rd_b), .i_wr_b(wr_b), .i_hi(hi),
        .i_port(pad), .o_port(mem_o));
    // ========================================
    // Tasks
    task close_out;
        if (n_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task mmw(input logic [7:0] v);
        @(negedge clk);
        mm_d = v;
        mm_we = 1;
        @(negedge clk);
        mm_we = 0;
    endtask
    // Request held until done; dropped in the done cycle so it is not retaken
    task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        int k;
        @(negedge clk);
        we = w;
        ad = a;
        wd = d;
        req = 1;
        for (k = 0; k < 40; k++) begin
            @(negedge clk);
            if (k == 0) chk(busy, 16'h0001);
            if (done === 1'b1) break;
        end
        req = 0;
        chk({done, busy}, 16'h0002);
        if (done !== 1'b1) begin
            n_errors++;
            close_out();
        end
    endtask
    // ========================================
    // Sequence
    initial begin
        repeat (4) @(negedge clk);
        chk({wr_oe, rd_oe, ale_oe}, 16'h0000);
        chk(mm_q & 8'hE7, 16'h0000);
        rst_b = 1;
        for (int i = 0; i < 8; i++) begin
            vs = i[2:0];
            ci = rows[i].idx;
            @(negedge clk);
            chk(va, rows[i].vec);
            chk(ca, 16'h0080 + {ci, 1'b0});
        end
        chk({wr_oe, rd_oe, ale_oe, nm, st}, 16'h001E);
        mmw(8'h9F);
        chk(mm_q, 16'h008F);
        rd_n = 0;
        wr_n = 0;
        acc(1, 16'h1000, 8'h5E);
        chk(wr_n[15:0], 16'h000A);
        chk(hi_seen, 16'h00FF);
        chk(rd_n[15:0], 16'h0000);
        acc(1, 16'h2000, 8'hA1);
        acc(0, 16'h1000, 8'h00);
        chk(rd, 16'h005E);
        chk(rd_n[15:0], 16'h000A);
        mmw(8'h9D);
        acc(0, 16'h1000, 8'h00);
        chk(hi_seen, 16'h000F);
        acc(1, 16'hFF10, 8'h3C);
        mmw(8'h87);
        acc(1, 16'hFF10, 8'h77);
        mmw(8'h8F);
        acc(0, 16'hFF10, 8'h00);
        chk(rd, 16'h003C);
        mmw(8'h87);
        acc(0, 16'hFF10, 8'h00);
        chk(rd, 16'h0077);
        mmw(8'h0F);
        acc(0, 16'h1000, 8'h00);
        chk(rd, 16'h00C3);
        chk(pa, 16'h1000);
        mmw(8'h08);
        acc(0, 16'h8000, 8'h00);
        chk(rd, 16'h00FF);
        mmw(8'h8F);
        stop_b = 0;
        repeat (5) @(negedge clk);
        chk({wr_oe, rd_oe, ale_oe, st}, 16'h0001);
        chk(mm_q, 16'h0008);
        stop_b = 1;
        ma = 1;
        mb = 0;
        rst_b = 0;
        repeat (5) @(negedge clk);
        chk({pm, mm_q}, 16'h0108);
        ma = 0;
        mb = 1;
        rst_b = 1;
        repeat (4) @(negedge clk);
        acc(0, 16'hFF10, 8'h00);
        chk(rd, 16'h003C);
        close_out();
    end
endmodule
